// ==== core/papc_top.v ====
/*
  Power control for the floppy controller, two serial ports and the
  parallel port, with an AXI4-Lite register slave.
  Assumes all inputs are synchronous to sys_clk_in and that the floppy
  and serial cores report their idle state on plain inputs.
*/
// Register access over AXI4-Lite was chosen for this implementation.
// Operation
// - Direct powerdown per unit from direct config
// - Floppy auto powerdown only when bit 0 set
// - Floppy sleeps: motors off, status 80H, idle
// - Ten millisecond timer must also expire
// - Clearing enable cancels timer, blocks auto powerdown
// - Rate select powerdown overrides auto powerdown
// - Reset wake resets; register wake keeps state
// - Wake on motor set, status, data access
// - Output or rate writes wake only on motor/reset
// - Wake restarts timer, sleeps again when idle
// - Other registers readable and writable while asleep
// - Host bus keeps working during powerdown
// - Drive outputs tristated, head outputs stay active
// - Serial auto enable bits 4,5; transmitter empty
// - Receiver sleeps when FIFO empty, awaiting start
// - Ring indicator change still reported while asleep
// - Buffer write or receive line change wakes
// - Parallel auto powerdown only when bit 3 set
// - Enhanced parallel logic off unless enabled, selected
// - Extended capability logic off per mode, re-evaluated
`timescale 1ns/100ps
`include "papc_defs.vh"

module papc_top #(
  parameter [23:0] AUTO_PD_CYCLES = `PAPC_AUTO_PD_CYCLES
) (
  input wire sys_clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire [31:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output wire [1:0] s_axi_bresp_out,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [31:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [7:0] fdc_status_a_in,
  input wire [7:0] fdc_status_b_in,
  input wire [7:0] fdc_main_status_in,
  input wire [7:0] fdc_data_in,
  input wire [7:0] fdc_drive_input_in,
  input wire fdc_int_in,
  input wire fdc_head_unload_done_in,
  output wire [7:0] fdc_dor_out,
  output wire [7:0] fdc_rate_select_out,
  output wire [7:0] fdc_config_control_out,
  output wire [7:0] fdc_data_wdata_out,
  output wire fdc_data_wr_out,
  output wire fdc_data_rd_out,
  output wire fdc_soft_reset_out,
  output wire fdc_wake_out,
  output wire fdc_powerdown_out,
  input wire motor_on_0_n_in,
  input wire drive_select_0_n_in,
  input wire write_stream_n_in,
  input wire write_enable_gate_n_in,
  input wire head_move_sense_n_in,
  input wire track_pulse_n_in,
  input wire side_select_n_in,
  input wire [1:0] density_select_in,
  output wire motor_on_0_n_out,
  output wire drive_select_0_n_out,
  output wire write_stream_n_out,
  output wire write_enable_gate_n_out,
  output wire floppy_drive_oe_out,
  output wire head_move_sense_n_out,
  output wire track_pulse_n_out,
  output wire side_select_n_out,
  output wire [1:0] density_select_out,
  input wire [1:0] uart_tx_empty_in,
  input wire [1:0] uart_tx_buf_wr_in,
  input wire [1:0] uart_rx_fifo_empty_in,
  input wire [1:0] uart_rx_idle_in,
  input wire [1:0] serial_receive_line_in,
  input wire [1:0] phone_line_alert_input_in,
  output wire [1:0] uart_tx_pd_out,
  output wire [1:0] uart_rx_pd_out,
  output wire [1:0] uart_ring_delta_out,
  output wire epp_pd_out,
  output wire ecp_pd_out
);

  function papc_hit;
    input [31:0] addr;
    input is_wr;
    begin
      papc_hit = 1'b0;
      if (addr[31:6] == 26'h0000000) begin
        case (addr[5:2])
          `PAPC_IDX_DOR, `PAPC_IDX_RATE_MAIN, `PAPC_IDX_DATA: papc_hit = 1'b1;
          `PAPC_IDX_DIRECT_PWR, `PAPC_IDX_AUTO_PWR, `PAPC_IDX_PAR_CFG: papc_hit = 1'b1;
          `PAPC_IDX_DIR_CCR: papc_hit = 1'b1;
          `PAPC_IDX_STATUS_A, `PAPC_IDX_STATUS_B, `PAPC_IDX_PWR_STAT: papc_hit = ~is_wr;
          default: papc_hit = 1'b0;
        endcase
      end
    end
  endfunction

  // Bus slave state
  reg aw_full_q, w_full_q, bvalid_q, rvalid_q;
  reg awready_q, wready_q, arready_q;
  reg [31:0] awaddr_q, wdata_q, rdata_q;
  reg [3:0] wstrb_q;
  reg [1:0] bresp_q, rresp_q;
  // Register state
  reg [7:0] dor_q, dsr_q, ccr_q, direct_q, auto_q, par_q;
  reg [7:0] data_wdata_q;
  reg data_wr_q, data_rd_q, soft_reset_q, wake_q;
  // Floppy power state
  reg [23:0] tmr_q;
  reg tmr_done_q, auto_pd_q, dsr_pd_q, fdc_pd_q;
  reg mtr_q, ds_q, wd_q, wg_q, oe_q, dirp_q, step_q, side_q;
  reg [1:0] den_q;
  // Serial and parallel power state
  reg [1:0] tx_pd_q, rx_pd_q, rx_prev_q, ri_prev_q, ring_q;
  reg [1:0] tx_pd_out_q, rx_pd_out_q;
  reg epp_pd_q, ecp_pd_q;

  wire aw_take = s_axi_awvalid_in & awready_q;
  wire w_take = s_axi_wvalid_in & wready_q;
  wire ar_take = s_axi_arvalid_in & arready_q;
  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_ok = do_wr & papc_hit(awaddr_q, 1'b1) & wstrb_q[0];
  wire rd_ok = ar_take & papc_hit(s_axi_araddr_in, 1'b0);
  wire [3:0] wr_idx = awaddr_q[5:2];
  wire [3:0] rd_idx = s_axi_araddr_in[5:2];
  wire [7:0] wb = wdata_q[7:0];

  wire aw_full_d = (aw_full_q | aw_take) & ~do_wr;
  wire w_full_d = (w_full_q | w_take) & ~do_wr;
  wire bvalid_d = (bvalid_q & ~s_axi_bready_in) | do_wr;
  wire rvalid_d = (rvalid_q & ~s_axi_rready_in) | ar_take;

  wire dor_wr = wr_ok & (wr_idx == `PAPC_IDX_DOR);
  wire dsr_wr = wr_ok & (wr_idx == `PAPC_IDX_RATE_MAIN);
  wire dat_wr = wr_ok & (wr_idx == `PAPC_IDX_DATA);
  wire msr_rd = rd_ok & (rd_idx == `PAPC_IDX_RATE_MAIN);
  wire dat_rd = rd_ok & (rd_idx == `PAPC_IDX_DATA);

  wire motor_set = dor_wr & (wb[`PAPC_DOR_MOTOR_HI:`PAPC_DOR_MOTOR_LO] != 4'h0);
  // Register accesses that resume without disturbing the controller
  wire reg_wake = motor_set | msr_rd | dat_rd | dat_wr;
  // Software reset bits run the normal reset sequence instead
  wire rst_wake = (dor_wr & ~wb[`PAPC_DOR_RESET_N]) | (dsr_wr & wb[`PAPC_DSR_SW_RESET]);
  wire any_wake = reg_wake | rst_wake;

  wire fdc_auto_en = auto_q[`PAPC_PWR_FDC];
  wire fdc_idle = (dor_q[`PAPC_DOR_MOTOR_HI:`PAPC_DOR_MOTOR_LO] == 4'h0) &
    (fdc_main_status_in == `PAPC_MSR_IDLE) & ~fdc_int_in & fdc_head_unload_done_in;
  wire [2:0] par_mode = par_q[`PAPC_PAR_MODE_HI:`PAPC_PAR_MODE_LO];
  wire [1:0] uart_auto = {auto_q[`PAPC_PWR_UART1], auto_q[`PAPC_PWR_UART0]};
  wire [1:0] uart_direct = {direct_q[`PAPC_PWR_UART1], direct_q[`PAPC_PWR_UART0]};

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    // Status of sleeping units reads true values; only main status and data reads here wake them
    case (rd_idx)
      `PAPC_IDX_STATUS_A: rd_mux[7:0] = fdc_status_a_in;
      `PAPC_IDX_STATUS_B: rd_mux[7:0] = fdc_status_b_in;
      `PAPC_IDX_DOR: rd_mux[7:0] = dor_q;
      `PAPC_IDX_RATE_MAIN: rd_mux[7:0] = fdc_main_status_in;
      `PAPC_IDX_DATA: rd_mux[7:0] = fdc_data_in;
      `PAPC_IDX_DIR_CCR: rd_mux[7:0] = fdc_drive_input_in;
      `PAPC_IDX_DIRECT_PWR: rd_mux[7:0] = direct_q;
      `PAPC_IDX_AUTO_PWR: rd_mux[7:0] = auto_q;
      `PAPC_IDX_PAR_CFG: rd_mux[7:0] = par_q;
      `PAPC_IDX_PWR_STAT: rd_mux[8:0] = {rx_pd_out_q, tx_pd_out_q, ecp_pd_q, epp_pd_q,
        dsr_pd_q, auto_pd_q, fdc_pd_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Bus slave has no power gating so wake accesses are always seen
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      rdata_q <= 32'h00000000;
      bresp_q <= `PAPC_RESP_OKAY;
      rresp_q <= `PAPC_RESP_OKAY;
    end else if (ce_in) begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr_in;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        bresp_q <= papc_hit(awaddr_q, 1'b1) ? `PAPC_RESP_OKAY : `PAPC_RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_q <= rd_ok ? rd_mux : 32'h00000000;
        rresp_q <= rd_ok ? `PAPC_RESP_OKAY : `PAPC_RESP_SLVERR;
      end
    end
  end

  // Software registers and floppy strobes
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dor_q <= `PAPC_RST_BYTE;
      dsr_q <= `PAPC_RST_BYTE;
      ccr_q <= `PAPC_RST_BYTE;
      direct_q <= `PAPC_RST_BYTE;
      auto_q <= `PAPC_RST_BYTE;
      par_q <= `PAPC_RST_PAR_CFG;
      data_wdata_q <= `PAPC_RST_BYTE;
      data_wr_q <= 1'b0;
      data_rd_q <= 1'b0;
      soft_reset_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (ce_in) begin
      // Writes land even while asleep; the core sees them on waking
      if (dor_wr) begin
        dor_q <= wb;
      end
      if (dsr_wr) begin
        dsr_q <= wb;
      end
      if (wr_ok & (wr_idx == `PAPC_IDX_DIR_CCR)) begin
        ccr_q <= wb;
      end
      if (wr_ok & (wr_idx == `PAPC_IDX_DIRECT_PWR)) begin
        direct_q <= wb;
      end
      if (wr_ok & (wr_idx == `PAPC_IDX_AUTO_PWR)) begin
        auto_q <= wb;
      end
      if (wr_ok & (wr_idx == `PAPC_IDX_PAR_CFG)) begin
        par_q <= wb;
      end
      if (dat_wr) begin
        data_wdata_q <= wb;
      end
      data_wr_q <= dat_wr;
      data_rd_q <= dat_rd;
      soft_reset_q <= rst_wake;
      wake_q <= reg_wake & ~rst_wake;
    end
  end

  // Floppy powerdown: timer, auto state, rate select state
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tmr_q <= 24'h000000;
      tmr_done_q <= 1'b0;
      auto_pd_q <= 1'b0;
      dsr_pd_q <= 1'b0;
      fdc_pd_q <= 1'b0;
    end else if (ce_in) begin
      if (!fdc_auto_en) begin
        tmr_q <= 24'h000000;
        tmr_done_q <= 1'b0;
      end else if (any_wake) begin
        tmr_q <= 24'h000000;
        tmr_done_q <= 1'b0;
      end else if (!tmr_done_q) begin
        // Starts counting as soon as auto powerdown is enabled
        tmr_q <= tmr_q + 24'h000001;
        tmr_done_q <= (tmr_q == AUTO_PD_CYCLES - 24'h000001);
      end
      // Once asleep only a wake event or clearing the enable ends it, not a status change
      auto_pd_q <= fdc_auto_en & ~any_wake &
        (auto_pd_q | (tmr_done_q & fdc_idle));
      if (dsr_wr & wb[`PAPC_DSR_POWERDOWN] & ~wb[`PAPC_DSR_SW_RESET]) begin
        dsr_pd_q <= 1'b1;
      end else if (any_wake) begin
        dsr_pd_q <= 1'b0;
      end
      fdc_pd_q <= direct_q[`PAPC_PWR_FDC] | dsr_pd_q | auto_pd_q;
    end
  end

  // Drive pins: drive-facing outputs float, head control stays driven
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mtr_q <= 1'b1;
      ds_q <= 1'b1;
      wd_q <= 1'b1;
      wg_q <= 1'b1;
      oe_q <= 1'b0;
      dirp_q <= 1'b1;
      step_q <= 1'b1;
      side_q <= 1'b1;
      den_q <= 2'h0;
    end else if (ce_in) begin
      mtr_q <= motor_on_0_n_in;
      ds_q <= drive_select_0_n_in;
      wd_q <= write_stream_n_in;
      wg_q <= write_enable_gate_n_in;
      oe_q <= ~fdc_pd_q;
      dirp_q <= head_move_sense_n_in;
      step_q <= track_pulse_n_in;
      side_q <= side_select_n_in;
      den_q <= density_select_in;
    end
  end

  // Serial ports and parallel port
  integer i;
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_pd_q <= 2'h0;
      rx_pd_q <= 2'h0;
      rx_prev_q <= 2'h3;
      ri_prev_q <= 2'h0;
      ring_q <= 2'h0;
      tx_pd_out_q <= 2'h0;
      rx_pd_out_q <= 2'h0;
      epp_pd_q <= 1'b0;
      ecp_pd_q <= 1'b0;
    end else if (ce_in) begin
      rx_prev_q <= serial_receive_line_in;
      ri_prev_q <= phone_line_alert_input_in;
      // Ring detection sits outside the gated logic
      ring_q <= phone_line_alert_input_in ^ ri_prev_q;
      for (i = 0; i < 2; i = i + 1) begin
        tx_pd_q[i] <= uart_auto[i] & ~uart_tx_buf_wr_in[i] &
          (tx_pd_q[i] | uart_tx_empty_in[i]);
        rx_pd_q[i] <= uart_auto[i] & (serial_receive_line_in[i] == rx_prev_q[i]) &
          (rx_pd_q[i] | (uart_rx_fifo_empty_in[i] & uart_rx_idle_in[i]));
      end
      tx_pd_out_q <= uart_direct | tx_pd_q;
      rx_pd_out_q <= uart_direct | rx_pd_q;
      // Evaluated every cycle so any mode change takes effect on the next clock
      epp_pd_q <= direct_q[`PAPC_PWR_PAR] | (auto_q[`PAPC_PWR_PAR] &
        (~par_q[`PAPC_PAR_EPP_EN] |
        (par_q[`PAPC_PAR_ECP_EN] & (par_mode != `PAPC_MODE_EPP))));
      ecp_pd_q <= direct_q[`PAPC_PWR_PAR] | (auto_q[`PAPC_PWR_PAR] &
        (~par_q[`PAPC_PAR_ECP_EN] | (par_mode == `PAPC_MODE_SPP) |
        (par_mode == `PAPC_MODE_BIDIR) | (par_mode == `PAPC_MODE_EPP)));
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign fdc_dor_out = dor_q;
  assign fdc_rate_select_out = dsr_q;
  assign fdc_config_control_out = ccr_q;
  assign fdc_data_wdata_out = data_wdata_q;
  assign fdc_data_wr_out = data_wr_q;
  assign fdc_data_rd_out = data_rd_q;
  assign fdc_soft_reset_out = soft_reset_q;
  assign fdc_wake_out = wake_q;
  assign fdc_powerdown_out = fdc_pd_q;
  assign motor_on_0_n_out = mtr_q;
  assign drive_select_0_n_out = ds_q;
  assign write_stream_n_out = wd_q;
  assign write_enable_gate_n_out = wg_q;
  assign floppy_drive_oe_out = oe_q;
  assign head_move_sense_n_out = dirp_q;
  assign track_pulse_n_out = step_q;
  assign side_select_n_out = side_q;
  assign density_select_out = den_q;
  assign uart_tx_pd_out = tx_pd_out_q;
  assign uart_rx_pd_out = rx_pd_out_q;
  assign uart_ring_delta_out = ring_q;
  assign epp_pd_out = epp_pd_q;
  assign ecp_pd_out = ecp_pd_q;

endmodule // papc_top

// ==== core/papc_defs.vh ====
/*
  Constants for the peripheral power control block: register indices,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the design file only.
*/
`ifndef PAPC_DEFS_VH
`define PAPC_DEFS_VH

// Register indices, byte address is four times the index
`define PAPC_IDX_STATUS_A 4'h0
`define PAPC_IDX_STATUS_B 4'h1
`define PAPC_IDX_DOR 4'h2
`define PAPC_IDX_RATE_MAIN 4'h4
`define PAPC_IDX_DATA 4'h5
`define PAPC_IDX_DIR_CCR 4'h7
`define PAPC_IDX_DIRECT_PWR 4'h8
`define PAPC_IDX_AUTO_PWR 4'h9
`define PAPC_IDX_PWR_STAT 4'hA
`define PAPC_IDX_PAR_CFG 4'hB

// Field positions
`define PAPC_DOR_MOTOR_HI 7
`define PAPC_DOR_MOTOR_LO 4
`define PAPC_DOR_RESET_N 2
`define PAPC_DSR_SW_RESET 7
`define PAPC_DSR_POWERDOWN 6
`define PAPC_PWR_FDC 0
`define PAPC_PWR_PAR 3
`define PAPC_PWR_UART0 4
`define PAPC_PWR_UART1 5
`define PAPC_PAR_EPP_EN 0
`define PAPC_PAR_ECP_EN 1
`define PAPC_PAR_MODE_HI 4
`define PAPC_PAR_MODE_LO 2

// Extended control mode codes
`define PAPC_MODE_SPP 3'h0
`define PAPC_MODE_BIDIR 3'h1
`define PAPC_MODE_EPP 3'h4

// Reset values and the idle main status value
`define PAPC_RST_BYTE 8'h00
`define PAPC_RST_PAR_CFG 8'h00
`define PAPC_MSR_IDLE 8'h80

// Timing
`define PAPC_CLK_MHZ 24'h000064
`define PAPC_AUTO_PD_MS 24'h00000A
`define PAPC_AUTO_PD_CYCLES (`PAPC_AUTO_PD_MS * 24'h0003E8 * `PAPC_CLK_MHZ)
`define PAPC_HOST_WAIT_AUTO_US 8
`define PAPC_HOST_WAIT_250K_US 8
`define PAPC_HOST_WAIT_500K_US 4
`define PAPC_HOST_WAIT_AUTO_CYCLES (`PAPC_HOST_WAIT_AUTO_US * `PAPC_CLK_MHZ)

// AXI responses
`define PAPC_RESP_OKAY 2'h0
`define PAPC_RESP_SLVERR 2'h2

`endif

// ==== testbench/papc_properties.sv ====
/* Port timing checks for papc_top.
   Assumes one clock domain and a bind onto papc_top. */
`timescale 1ns/100ps
module papc_properties (
  input wire sys_clk_in,
  input wire rstn_in,
  input wire [31:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire [1:0] s_axi_bresp_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire fdc_wake_out,
  input wire fdc_soft_reset_out,
  input wire fdc_powerdown_out,
  input wire floppy_drive_oe_out,
  input wire track_pulse_n_in,
  input wire track_pulse_n_out,
  input wire [1:0] phone_line_alert_input_in,
  input wire [1:0] uart_ring_delta_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_rd_lat; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |-> ##[1:2] s_axi_bvalid_out;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_msr_wake; s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 32'h10 |-> ##[1:2] fdc_wake_out; endproperty
  a_msr_wake: assert property (p_msr_wake) else $error("status read did not wake");
  property p_dor_quiet; s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 32'h08 |=> !fdc_wake_out [*2]; endproperty
  a_dor_quiet: assert property (p_dor_quiet) else $error("output reg read woke");
  property p_rst_first; fdc_soft_reset_out |-> !fdc_wake_out; endproperty
  a_rst_first: assert property (p_rst_first) else $error("reset and wake together");
  property p_pd_tri; fdc_powerdown_out |=> !floppy_drive_oe_out; endproperty
  a_pd_tri: assert property (p_pd_tri) else $error("drive pins driven while asleep");
  property p_awake_drv; rstn_in && !fdc_powerdown_out |=> floppy_drive_oe_out; endproperty
  a_awake_drv: assert property (p_awake_drv) else $error("drive pins released while awake");
  property p_step_live; rstn_in |=> track_pulse_n_out == $past(track_pulse_n_in); endproperty
  a_step_live: assert property (p_step_live) else $error("step pin not following");
  property p_ring;
    phone_line_alert_input_in[0] != $past(phone_line_alert_input_in[0]) |-> ##[1:2] uart_ring_delta_out[0];
  endproperty
  a_ring: assert property (p_ring) else $error("ring change not reported");
endmodule // papc_properties
bind papc_top papc_properties u_props (.*);

// ==== testbench/papc_far_model.sv ====
/* Floppy core and serial port cores as seen by the power block.
   Assumes the bench raises send_in for one cycle per byte. */
`timescale 1ns/100ps
module papc_far_model (
  input wire sys_clk_in,
  input wire [7:0] dor_in,
  input wire [1:0] send_in,
  input wire [1:0] rx_line_in,
  output logic [7:0] main_status_out,
  output logic head_done_out,
  output logic [1:0] tx_wr_out,
  output logic [1:0] tx_empty_out,
  output logic [1:0] rx_idle_out
);
  logic [1:0][3:0] tx_cnt = '0;
  logic [1:0][4:0] rx_cnt = '0;
  logic [1:0] line_q = '1;
  // Spinning motors keep the core busy and the heads loaded
  assign main_status_out = (dor_in[7:4] != 4'h0) ? 8'h90 : 8'h80;
  assign head_done_out = dor_in[7:4] == 4'h0;
  // Status follows the counters at once so a new frame never looks idle
  assign tx_empty_out = {tx_cnt[1] == 4'h0, tx_cnt[0] == 4'h0};
  assign rx_idle_out = {rx_cnt[1] == 5'h0, rx_cnt[0] == 5'h0};
  always @(posedge sys_clk_in) begin
    line_q <= rx_line_in;
    for (int i = 0; i < 2; i++) begin
      tx_wr_out[i] <= send_in[i];
      tx_cnt[i] <= send_in[i] ? 4'hF : (tx_cnt[i] != 4'h0 ? tx_cnt[i] - 4'h1 : 4'h0);
      // A line edge starts a frame, so the receiver is busy for a while
      rx_cnt[i] <= (rx_line_in[i] != line_q[i]) ? 5'h14 : (rx_cnt[i] != 5'h0 ? rx_cnt[i] - 5'h1 : 5'h0);
    end
  end
endmodule // papc_far_model

// ==== testbench/papc_top_test.sv ====
/* Self-checking bench for papc_top over AXI4-Lite.
   Assumes a 100 MHz clock and a shortened powerdown timer. */
`timescale 1ns/100ps
module papc_top_test;
  logic sys_clk_in = 0, rstn_in = 0, ce_in = 1;
  logic [31:0] s_axi_awaddr_in = 0, s_axi_wdata_in = 0, s_axi_araddr_in = 0;
  logic [3:0] s_axi_wstrb_in = 0;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, fdc_int_in = 0;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  logic [7:0] fdc_status_a_in = 0, fdc_status_b_in = 0, fdc_data_in = 0, fdc_drive_input_in = 0;
  wire [7:0] fdc_main_status_in, fdc_dor_out, fdc_rate_select_out;
  wire [7:0] fdc_config_control_out, fdc_data_wdata_out;
  wire fdc_head_unload_done_in, fdc_data_wr_out, fdc_data_rd_out;
  wire fdc_soft_reset_out, fdc_wake_out, fdc_powerdown_out;
  logic motor_on_0_n_in = 1, drive_select_0_n_in = 1, write_stream_n_in = 1;
  logic write_enable_gate_n_in = 1, head_move_sense_n_in = 1, track_pulse_n_in = 1;
  logic side_select_n_in = 1;
  logic [1:0] density_select_in = 0, serial_receive_line_in = 2'h3;
  logic [1:0] phone_line_alert_input_in = 0, send = 0;
  wire motor_on_0_n_out, drive_select_0_n_out, write_stream_n_out, write_enable_gate_n_out;
  wire floppy_drive_oe_out, head_move_sense_n_out, track_pulse_n_out, side_select_n_out;
  wire [1:0] density_select_out, uart_tx_empty_in, uart_tx_buf_wr_in, uart_rx_idle_in;
  wire [1:0] uart_tx_pd_out, uart_rx_pd_out, uart_ring_delta_out;
  wire epp_pd_out, ecp_pd_out;
  wire [1:0] uart_rx_fifo_empty_in = uart_rx_idle_in;
  int fails = 0, num_checks = 0, seed;
  logic [33:0] exp_q[$];
  logic [7:0] cfg [6] = '{8'h00, 8'h01, 8'h12, 8'h13, 8'h0F, 8'h07};
  logic [1:0] pex [6] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h2, 2'h3};

  papc_top #(.AUTO_PD_CYCLES(24'h32)) DUT (.*);
  papc_far_model u_far (.sys_clk_in(sys_clk_in), .dor_in(fdc_dor_out), .send_in(send),
    .rx_line_in(serial_receive_line_in), .main_status_out(fdc_main_status_in),
    .head_done_out(fdc_head_unload_done_in), .tx_wr_out(uart_tx_buf_wr_in),
    .tx_empty_out(uart_tx_empty_in), .rx_idle_out(uart_rx_idle_in));

  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    {motor_on_0_n_in, drive_select_0_n_in, write_stream_n_in, write_enable_gate_n_in,
      head_move_sense_n_in, track_pulse_n_in, side_select_n_in, density_select_in} <= 9'($urandom);
  end
  always @(posedge sys_clk_in) begin
    if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in && exp_q.size() > 0) begin
      cmp({s_axi_rresp_out, s_axi_rdata_out}, exp_q.pop_front());
    end
  end

  task cmp(input [33:0] got, input [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Ends just after an edge so outputs read by the caller have settled
  task wt(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task wr(input [31:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
    int n;
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_bready_in <= 1;
    for (n = 0; n < 100 && !(s_axi_bvalid_out === 1'b1 && s_axi_bready_in); n++) begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out === 1'b1 && s_axi_awvalid_in) s_axi_awvalid_in <= 0;
      if (s_axi_wready_out === 1'b1 && s_axi_wvalid_in) s_axi_wvalid_in <= 0;
    end
    if (n == 100) begin
      fails++;
      close_out;
    end
    s_axi_bready_in <= 0;
    cmp(s_axi_bresp_out, e);
  endtask
  task rd(input [31:0] a, input [31:0] d, input [1:0] e);
    int n;
    @(posedge sys_clk_in);
    exp_q.push_back({e, d});
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    s_axi_rready_in <= 1;
    for (n = 0; n < 100 && !(s_axi_rvalid_out === 1'b1 && s_axi_rready_in); n++) begin
      @(posedge sys_clk_in);
      if (s_axi_arready_out === 1'b1 && s_axi_arvalid_in) s_axi_arvalid_in <= 0;
    end
    if (n == 100) begin
      fails++;
      close_out;
    end
    s_axi_rready_in <= 0;
  endtask

  initial begin
    #900000;
    fails++;
    close_out;
  end
  initial begin
    seed = $urandom(32'hB581);
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1;
    {fdc_status_a_in, fdc_status_b_in, fdc_data_in, fdc_drive_input_in} <= $urandom;
    repeat (2) @(posedge sys_clk_in);
    rd(32'h20, 32'h0, 2'h0);
    rd(32'h0C, 32'h0, 2'h2);
    rd(32'h00, {24'h0, fdc_status_a_in}, 2'h0);
    rd(32'h04, {24'h0, fdc_status_b_in}, 2'h0);
    rd(32'h1C, {24'h0, fdc_drive_input_in}, 2'h0);
    wr(32'h00, 32'h1, 4'hF, 2'h2);
    wr(32'h08, 32'hF0, 4'h0, 2'h0);
    wr(32'h08, 32'hFFFFFF04, 4'hF, 2'h0);
    rd(32'h08, 32'h04, 2'h0);
    wr(32'h24, 32'h1, 4'hF, 2'h0);
    wt(20); cmp(fdc_powerdown_out, 0);
    wt(60); cmp(fdc_powerdown_out, 1);
    cmp(floppy_drive_oe_out, 0);
    rd(32'h08, 32'h04, 2'h0);
    wr(32'h1C, 32'h02, 4'hF, 2'h0);
    wt(3); cmp(fdc_powerdown_out, 1);
    cmp(fdc_config_control_out, 8'h02);
    rd(32'h10, 32'h80, 2'h0);
    wt(3); cmp(fdc_powerdown_out, 0);
    wt(800);
    cmp(fdc_powerdown_out, 1);
    rd(32'h14, {24'h0, fdc_data_in}, 2'h0);
    fdc_int_in <= 1;
    wt(20); cmp(fdc_powerdown_out, 0);
    wt(60); cmp(fdc_powerdown_out, 0);
    fdc_int_in <= 0;
    wt(10); cmp(fdc_powerdown_out, 1);
    wr(32'h08, 32'h14, 4'hF, 2'h0);
    cmp(fdc_dor_out, 8'h14);
    wt(80); cmp(fdc_powerdown_out, 0);
    wr(32'h08, 32'h04, 4'hF, 2'h0);
    wt(80); cmp(fdc_powerdown_out, 1);
    wr(32'h08, 32'h0C, 4'hF, 2'h0);
    wr(32'h10, 32'h02, 4'hF, 2'h0);
    cmp(fdc_rate_select_out, 8'h02);
    wt(3); cmp(fdc_powerdown_out, 1);
    wr(32'h10, 32'h40, 4'hF, 2'h0);
    wr(32'h10, 32'h80, 4'hF, 2'h0);
    wt(3); cmp(fdc_powerdown_out, 0);
    wt(80); cmp(fdc_powerdown_out, 1);
    wr(32'h24, 32'h0, 4'hF, 2'h0);
    wt(3); cmp(fdc_powerdown_out, 0);
    wr(32'h10, 32'h40, 4'hF, 2'h0);
    wt(80); cmp(fdc_powerdown_out, 1);
    wr(32'h08, 32'h00, 4'hF, 2'h0);
    wt(3); cmp(fdc_powerdown_out, 0);
    wr(32'h20, 32'h1, 4'hF, 2'h0);
    rd(32'h28, 32'h1, 2'h0);
    wr(32'h20, 32'h0, 4'hF, 2'h0);
    wt(3); cmp(fdc_powerdown_out, 0);
    wr(32'h14, 32'hA5, 4'hF, 2'h0);
    cmp(fdc_data_wdata_out, 8'hA5);
    wt(800);
    wr(32'h24, 32'h30, 4'hF, 2'h0);
    wt(5); cmp({uart_tx_pd_out, uart_rx_pd_out}, 4'hF);
    send <= 2'h1;
    wt(1);
    send <= 2'h0;
    serial_receive_line_in[1] <= 0;
    phone_line_alert_input_in[0] <= 1;
    wt(4); cmp({uart_tx_pd_out, uart_rx_pd_out}, 4'h9);
    wr(32'h24, 32'h08, 4'hF, 2'h0);
    for (int i = 0; i < 6; i++) begin
      wr(32'h2C, {24'h0, cfg[i]}, 4'hF, 2'h0);
      wt(3); cmp({epp_pd_out, ecp_pd_out}, pex[i]);
    end
    wr(32'h24, 32'h0, 4'hF, 2'h0);
    wt(3); cmp({epp_pd_out, ecp_pd_out}, 2'h0);
    wr(32'h20, 32'h08, 4'hF, 2'h0);
    wt(3); cmp({epp_pd_out, ecp_pd_out}, 2'h3);
    close_out;
  end
endmodule // papc_top_test
